// *** jifp_flash_programmer.sv ***
/*
 jifp_flash_programmer: indirect data registers reached through the test port, driving a
 simple flash request/done port. assumes the test access state machine lives outside and
 hands over the instruction code, capture/shift/update strobes and tck/tdi on pins.
*/
`timescale 1ns/100ps
`default_nettype none
module jifp_flash_programmer
   import jifp_pkg::*;
#(
   parameter logic [15:0] LOCK_RD_ADDR = 16'hfbfe,
   parameter logic [15:0] LOCK_WR_ADDR = 16'hfbff
)(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        tck_pin,
   input  wire logic        tdi_pin,
   input  wire logic [15:0] ir_code,
   input  wire logic        capture_dr,
   input  wire logic        shift_dr,
   input  wire logic        update_dr,
   output logic             tdo_out,
   output logic             flash_req,
   output logic [1:0]       flash_cmd,
   output logic             flash_scratch,
   output logic             flash_all_user,
   output logic [15:0]      flash_addr,
   output logic [7:0]       flash_wdata,
   input  wire logic        flash_done,
   input  wire logic        flash_fail,
   input  wire logic [7:0]  flash_rdata
);
   // ***************************************************************
   // pin synchronisers and tck edge detection
   // ***************************************************************
   logic [1:0] tck_sync_ff, tdi_sync_ff, cap_sync_ff, sh_sync_ff, up_sync_ff;
   logic [15:0] ir_meta_ff, ir_sync_ff;   // instruction code arrives on the same lag as capture
   logic       tck_last_ff;
   logic       tck_rise;
   logic       tck_fall;
   // two stages per pin input; only the second stage is read
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tck_sync_ff <= 2'h0;
         tdi_sync_ff <= 2'h0;
         cap_sync_ff <= 2'h0;
         sh_sync_ff  <= 2'h0;
         up_sync_ff  <= 2'h0;
         ir_meta_ff  <= '0;
         ir_sync_ff  <= '0;
         tck_last_ff <= 1'b0;
      end
      else
      begin
         tck_sync_ff <= {tck_sync_ff[0], tck_pin};
         tdi_sync_ff <= {tdi_sync_ff[0], tdi_pin};
         cap_sync_ff <= {cap_sync_ff[0], capture_dr};
         sh_sync_ff  <= {sh_sync_ff[0], shift_dr};
         up_sync_ff  <= {up_sync_ff[0], update_dr};
         ir_meta_ff  <= ir_code;
         ir_sync_ff  <= ir_meta_ff;
         tck_last_ff <= tck_sync_ff[1];
      end
   end
   assign tck_rise = tck_sync_ff[1] & ~tck_last_ff;
   assign tck_fall = ~tck_sync_ff[1] & tck_last_ff;

   // ***************************************************************
   // operation sequencer state
   // ***************************************************************
   typedef enum logic [2:0]
   {
      JIFP_IDLE = 3'b001,
      JIFP_REG  = 3'b010,
      JIFP_MEM  = 3'b100
   } jifp_state_t;
   localparam logic [1:0] CMD_READ  = 2'h0;
   localparam logic [1:0] CMD_PROG  = 2'h1;
   localparam logic [1:0] CMD_ERASE = 2'h2;

   jifp_state_t state_ff, nxt_state;
   logic [JIFP_WORD_W-1:0] sreg_ff, nxt_sreg;
   logic [5:0]  nbits_ff, nxt_nbits;       // bits shifted since capture
   logic        busy_ff, nxt_busy;         // indirect busy
   logic        pend_ff, nxt_pend;         // command held off while busy
   logic [1:0]  pop_ff, nxt_pop;
   logic [JIFP_PAY_W-1:0] ppay_ff, nxt_ppay;
   logic [JIFP_PAY_W-1:0] rres_ff, nxt_rres;
   logic [7:0]  mode_ff, nxt_mode;
   logic [9:0]  port_ff, nxt_port;
   logic [15:0] tgt_ff, nxt_tgt;
   logic        unread_ff, nxt_unread;     // port data not yet consumed
   logic [1:0]  fcmd_ff, nxt_fcmd;
   logic        freq_ff, nxt_freq;
   logic        tdo_ff, nxt_tdo;
   logic        all_user_ff, nxt_all_user;
   logic [31:0] ident;
   logic        sel_ind;
   logic        ind_ir;
   logic [2:0]  wr_mode;
   logic [3:0]  rd_mode;

   assign ident   = {JIFP_ID_VERSION, JIFP_ID_PART, JIFP_ID_MAKER, 1'b1};
   assign ind_ir  = (ir_sync_ff == JIFP_IR_MODE_CTRL) || (ir_sync_ff == JIFP_IR_BYTE_PORT)
                    || (ir_sync_ff == JIFP_IR_TARGET);
   assign wr_mode = mode_ff[JIFP_WR_HI:JIFP_WR_LO];
   assign rd_mode = mode_ff[JIFP_RD_HI:JIFP_RD_LO];

   // next state of shifter, registers and flash sequencer
   always_comb
   begin
      logic [1:0]            op;
      logic [JIFP_PAY_W-1:0] pay;
      logic                  go;
      logic [JIFP_WORD_W-1:0] w;
      nxt_state    = state_ff;
      nxt_sreg     = sreg_ff;
      nxt_nbits    = nbits_ff;
      nxt_busy     = busy_ff;
      nxt_pend     = pend_ff;
      nxt_pop      = pop_ff;
      nxt_ppay     = ppay_ff;
      nxt_rres     = rres_ff;
      nxt_mode     = mode_ff;
      nxt_port     = port_ff;
      nxt_tgt      = tgt_ff;
      nxt_unread   = unread_ff;
      nxt_fcmd     = fcmd_ff;
      nxt_freq     = 1'b0;
      nxt_tdo      = tdo_ff;
      nxt_all_user = all_user_ff;
      op           = pop_ff;
      pay          = ppay_ff;
      go           = 1'b0;
      w            = '0;
      sel_ind      = ind_ir;
      // capture: identity word under JIFP_IR_IDENT, otherwise busy in bit 0, right-justified result above it
      if (cap_sync_ff[1])
      begin
         nxt_nbits = 6'h0;
         if (ir_sync_ff == JIFP_IR_IDENT)
            nxt_sreg = ident[JIFP_WORD_W-1:0];
         else
            nxt_sreg = {1'b0, rres_ff, busy_ff};
         nxt_tdo = (ir_sync_ff == JIFP_IR_IDENT) ? ident[0] : busy_ff;
         // busy read low releases a held-off command
         if (sel_ind && !busy_ff && pend_ff)
         begin
            go       = 1'b1;
            nxt_pend = 1'b0;
         end
      end
      else if (sh_sync_ff[1] && tck_rise)
      begin
         // lsb out first; incoming bits enter at the top so a short shift lands left-justified
         nxt_sreg  = {tdi_sync_ff[1], sreg_ff[JIFP_WORD_W-1:1]};
         nxt_nbits = (nbits_ff == 6'h3f) ? nbits_ff : nbits_ff + 6'h1;
      end
      else if (sh_sync_ff[1] && tck_fall)
         nxt_tdo = sreg_ff[0];
      else if (up_sync_ff[1] && sel_ind && nbits_ff >= 6'd2)
      begin
         // clear the stale bits below the shifted ones; the opcode already sits at 19:18; the update level lasts
         // several cycles, so the bit count is cleared to act on it only once
         nxt_nbits = 6'h0;
         w   = sreg_ff >> (JIFP_WORD_W - ((nbits_ff > 6'd20) ? 20 : int'(nbits_ff)));
         w   = w << (JIFP_WORD_W - ((nbits_ff > 6'd20) ? 20 : int'(nbits_ff)));
         op  = w[JIFP_OP_HI:JIFP_OP_LO];
         pay = w[JIFP_PAY_MSB:0];
         if (op[1])
         begin
            if (busy_ff)
            begin
               nxt_pend = 1'b1;
               nxt_pop  = op;
               nxt_ppay = pay;
            end
            else
               go = 1'b1;
         end
      end
      else if (tck_fall)
         nxt_tdo = (ir_sync_ff == JIFP_IR_IDENT) ? ident[0] : tdo_ff;

      // start an indirect read or write on the selected register
      if (go)
      begin
         nxt_busy = 1'b1;
         nxt_rres = '0;
         if (!op[0])
         begin
            case (ir_sync_ff)
               JIFP_IR_MODE_CTRL: nxt_rres = {10'h0, mode_ff};
               JIFP_IR_TARGET:    nxt_rres = {2'h0, tgt_ff};
               default:
               begin
                  nxt_rres   = {8'h0, port_ff};
                  nxt_unread = 1'b0;
                  if (!port_ff[0] && ((rd_mode == JIFP_RD_BLOCK) ||
                      (rd_mode == JIFP_RD_SINGLE && !unread_ff)))
                  begin
                     nxt_fcmd = CMD_READ;
                     nxt_freq = 1'b1;
                     nxt_port = {port_ff[9:1], 1'b1};
                  end
               end
            endcase
         end
         else
         begin
            case (ir_sync_ff)
               JIFP_IR_MODE_CTRL: nxt_mode = pay[17:10];
               JIFP_IR_TARGET:    nxt_tgt  = pay[17:2];
               default:
               begin
                  if (!port_ff[0])
                  begin
                     nxt_port[9:2] = pay[17:10];
                     if (wr_mode == JIFP_WR_PROG)
                     begin
                        nxt_fcmd = CMD_PROG;
                        nxt_freq = 1'b1;
                        nxt_port[0] = 1'b1;
                     end
                     else if (wr_mode == JIFP_WR_ERASE && pay[17:10] == JIFP_ERASE_KEY)
                     begin
                        nxt_fcmd     = CMD_ERASE;
                        nxt_freq     = 1'b1;
                        nxt_port[0]  = 1'b1;
                        nxt_all_user = (tgt_ff == LOCK_RD_ADDR) ||
                                       (tgt_ff == LOCK_WR_ADDR);
                     end
                  end
               end
            endcase
         end
         nxt_state = nxt_freq ? JIFP_MEM : JIFP_REG;
      end
      else
      begin
         case (state_ff)
            JIFP_IDLE: nxt_state = JIFP_IDLE;
            JIFP_REG:
            begin
               nxt_busy  = 1'b0;
               nxt_state = JIFP_IDLE;
            end
            JIFP_MEM:
            begin
               if (flash_done)
               begin
                  nxt_busy     = 1'b0;
                  nxt_state    = JIFP_IDLE;
                  nxt_port[1]  = flash_fail;
                  nxt_port[0]  = 1'b0;
                  nxt_all_user = 1'b0;
                  if (fcmd_ff == CMD_READ)
                  begin
                     nxt_port[9:2] = flash_rdata;
                     nxt_unread    = 1'b1;
                  end
                  if (fcmd_ff != CMD_ERASE)
                     nxt_tgt = tgt_ff + 16'h1;
               end
            end
            default: nxt_state = JIFP_IDLE;
         endcase
      end
   end

   // registers only
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff    <= JIFP_IDLE;
         sreg_ff     <= '0;
         nbits_ff    <= 6'h0;
         busy_ff     <= 1'b0;
         pend_ff     <= 1'b0;
         pop_ff      <= 2'h0;
         ppay_ff     <= '0;
         rres_ff     <= '0;
         mode_ff     <= JIFP_MODE_RST;
         port_ff     <= JIFP_PORT_RST;
         tgt_ff      <= JIFP_TGT_RST;
         unread_ff   <= 1'b0;
         fcmd_ff     <= 2'h0;
         freq_ff     <= 1'b0;
         tdo_ff      <= 1'b0;
         all_user_ff <= 1'b0;
      end
      else
      begin
         state_ff    <= nxt_state;
         sreg_ff     <= nxt_sreg;
         nbits_ff    <= nxt_nbits;
         busy_ff     <= nxt_busy;
         pend_ff     <= nxt_pend;
         pop_ff      <= nxt_pop;
         ppay_ff     <= nxt_ppay;
         rres_ff     <= nxt_rres;
         mode_ff     <= nxt_mode;
         port_ff     <= nxt_port;
         tgt_ff      <= nxt_tgt;
         unread_ff   <= nxt_unread;
         fcmd_ff     <= nxt_fcmd;
         freq_ff     <= nxt_freq;
         tdo_ff      <= nxt_tdo;
         all_user_ff <= nxt_all_user;
      end
   end

   // flash port; scratchpad wraps inside 0x00-0x7f, wider addresses are undefined anyway
   assign flash_req      = freq_ff;
   assign flash_cmd      = fcmd_ff;
   assign flash_scratch  = mode_ff[JIFP_SCRATCH_BIT];
   assign flash_addr     = mode_ff[JIFP_SCRATCH_BIT] ?
                           {9'h0, tgt_ff[6:0] & JIFP_SCRATCH_MAX} : tgt_ff;
   assign flash_wdata    = port_ff[9:2];
   assign flash_all_user = all_user_ff;
   assign tdo_out        = tdo_ff;
endmodule : jifp_flash_programmer
`default_nettype wire

// *** jifp_pkg.sv ***
/*
 jifp_pkg: constants for the indirect flash programming path behind the test port.
 assumes: the test access controller outside supplies instruction code, shift and update strobes.
*/
`default_nettype none
package jifp_pkg;
   // ***************************************************************
   // instruction codes
   // ***************************************************************
   localparam logic [15:0] JIFP_IR_IDENT     = 16'h0004;
   localparam logic [15:0] JIFP_IR_MODE_CTRL = 16'h0082;
   localparam logic [15:0] JIFP_IR_BYTE_PORT = 16'h0083;
   localparam logic [15:0] JIFP_IR_TARGET    = 16'h0084;
   // ***************************************************************
   // indirect word layout
   // ***************************************************************
   localparam int JIFP_WORD_W  = 20;
   localparam int JIFP_OP_HI   = 19;
   localparam int JIFP_OP_LO   = 18;
   localparam int JIFP_PAY_MSB = 17;
   localparam int JIFP_PAY_W   = 18;
   // ***************************************************************
   // mode control fields and reset values
   // ***************************************************************
   localparam int JIFP_SCRATCH_BIT = 7;
   localparam int JIFP_WR_HI       = 6;
   localparam int JIFP_WR_LO       = 4;
   localparam int JIFP_RD_HI       = 3;
   localparam int JIFP_RD_LO       = 0;
   localparam logic [7:0]  JIFP_MODE_RST  = 8'h00;
   localparam logic [9:0]  JIFP_PORT_RST  = 10'h000;
   localparam logic [15:0] JIFP_TGT_RST   = 16'h0000;
   localparam logic [2:0]  JIFP_WR_STORE  = 3'h0;
   localparam logic [2:0]  JIFP_WR_PROG   = 3'h1;
   localparam logic [2:0]  JIFP_WR_ERASE  = 3'h2;
   localparam logic [3:0]  JIFP_RD_HOLD   = 4'h0;
   localparam logic [3:0]  JIFP_RD_BLOCK  = 4'h1;
   localparam logic [3:0]  JIFP_RD_SINGLE = 4'h2;
   localparam logic [7:0]  JIFP_ERASE_KEY = 8'ha5;
   localparam logic [6:0]  JIFP_SCRATCH_MAX = 7'h7f;
   // ***************************************************************
   // identity word fields (values arbitrary, not a real maker or part)
   // ***************************************************************
   localparam logic [3:0]  JIFP_ID_VERSION = 4'h1;
   localparam logic [15:0] JIFP_ID_PART    = 16'h00a1;
   localparam logic [10:0] JIFP_ID_MAKER   = 11'h055;
endpackage : jifp_pkg
`default_nettype wire

// *** jifp_flash_programmer_asserts.sv ***
/* jifp_flash_programmer_asserts: flash request port checks.
   assumes: bound to jifp_flash_programmer, core_clk domain only. */
`timescale 1ns/100ps
`default_nettype none
module jifp_fp_chk
   import jifp_pkg::*;
#(
   parameter logic [15:0] LOCK_RD_ADDR = 16'hfbfe,
   parameter logic [15:0] LOCK_WR_ADDR = 16'hfbff
)(
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        flash_req,
   input wire logic [1:0]  flash_cmd,
   input wire logic        flash_scratch,
   input wire logic        flash_all_user,
   input wire logic [15:0] flash_addr,
   input wire logic [7:0]  flash_wdata,
   input wire logic        flash_done
);
   logic        busy_ff, nxt_busy;
   logic [1:0]  cmd_ff, nxt_cmd;
   logic [15:0] addr_ff, nxt_addr;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // remember the operation in flight so its end is judged against its start
   always_comb
   begin
      nxt_busy = flash_req | (busy_ff & ~flash_done);
      nxt_cmd  = flash_req ? flash_cmd : cmd_ff;
      nxt_addr = flash_req ? flash_addr : addr_ff;
   end
   always_ff @(posedge core_clk or negedge rst_n)
      if (!rst_n)
         {busy_ff, cmd_ff, addr_ff} <= 19'h0;
      else
         {busy_ff, cmd_ff, addr_ff} <= {nxt_busy, nxt_cmd, nxt_addr};
   chk_req_pulse: assert property (flash_req |=> !flash_req)
      else $error("flash request longer than one cycle");
   chk_no_overlap: assert property (flash_req |-> !busy_ff)
      else $error("flash request during an active operation");
   chk_op_hold: assert property (busy_ff && !flash_req |->
      $stable(flash_addr) && $stable(flash_cmd) && $stable(flash_wdata))
      else $error("request fields moved during an operation");
   chk_erase_key: assert property (flash_req && flash_cmd == 2'h2 |->
      flash_wdata == JIFP_ERASE_KEY)
      else $error("erase started without the key byte");
   chk_whole_erase: assert property (flash_req && flash_cmd == 2'h2 && !flash_scratch |->
      flash_all_user == (flash_addr == LOCK_RD_ADDR || flash_addr == LOCK_WR_ADDR))
      else $error("whole erase flag wrong for the address");
   chk_scratch_range: assert property (flash_req && flash_scratch |->
      flash_addr[15:7] == 9'h000)
      else $error("scratch access outside the scratch sector");
   chk_ptr_step: assert property (busy_ff && flash_done && cmd_ff != 2'h2 |->
      ##[1:4] flash_addr == addr_ff + 16'h0001)
      else $error("pointer did not step after read or program");
   chk_erase_keep: assert property (busy_ff && flash_done && cmd_ff == 2'h2 |=>
      (flash_addr == addr_ff) [*4])
      else $error("pointer moved after erase");
endmodule : jifp_fp_chk
bind jifp_flash_programmer jifp_fp_chk
   #(.LOCK_RD_ADDR(LOCK_RD_ADDR), .LOCK_WR_ADDR(LOCK_WR_ADDR))
   i_jifp_fp_chk (.core_clk, .rst_n, .flash_req, .flash_cmd, .flash_scratch,
                  .flash_all_user, .flash_addr, .flash_wdata, .flash_done);
`default_nettype wire

// *** jifp_flash_model.sv ***
/* jifp_flash_model: behavioural flash array answering the request port.
   assumes: request fields stay put until done; done after wait_cycles. */
`timescale 1ns/100ps
`default_nettype none
module jifp_flash_model
   import jifp_pkg::*;
#(
   parameter logic [15:0] FAIL_ADDR = 16'h0400,
   parameter int          PAGE      = 512
)(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        flash_req,
   input  wire logic [1:0]  flash_cmd,
   input  wire logic        flash_scratch,
   input  wire logic        flash_all_user,
   input  wire logic [15:0] flash_addr,
   input  wire logic [7:0]  flash_wdata,
   input  wire logic [15:0] wait_cycles,
   output logic             flash_done,
   output logic             flash_fail,
   output logic [7:0]       flash_rdata
);
   logic [7:0]  main_mem [65536];
   logic [7:0]  scr_mem [128];
   logic [7:0]  q = 8'h00;
   logic        fq = 1'b0;
   logic        busy;
   logic [15:0] cnt;
   // released lines show the inverse, so stale data never looks valid
   assign flash_rdata = flash_done ? q : ~q;
   assign flash_fail  = flash_done ? fq : ~fq;
   initial
   begin
      foreach (main_mem[i]) main_mem[i] = 8'hff;
      foreach (scr_mem[i]) scr_mem[i] = 8'hff;
   end
   // count out the wait, then act; scratch erase is not modelled
   always @(posedge core_clk or negedge rst_n)
   begin
      flash_done <= 1'b0;
      if (!rst_n)
         busy = 1'b0;
      else if (flash_req)
      begin
         busy = 1'b1;
         cnt = 16'h0;
      end
      else if (busy && ++cnt >= wait_cycles)
      begin
         busy = 1'b0;
         flash_done <= 1'b1;
         fq = flash_cmd != 2'h0 && !flash_scratch && flash_addr == FAIL_ADDR;
         if (flash_cmd == 2'h0)
            q = flash_scratch ? scr_mem[flash_addr[6:0]] : main_mem[flash_addr];
         if (!fq && flash_cmd == 2'h1 && flash_scratch)
            scr_mem[flash_addr[6:0]] = flash_wdata;
         if (!fq && flash_cmd == 2'h1 && !flash_scratch)
            main_mem[flash_addr] = flash_wdata;
         if (!fq && flash_cmd == 2'h2 && !flash_scratch)
            for (int i = 0; i < 65536; i++)
               if (flash_all_user || i / PAGE == flash_addr / PAGE)
                  main_mem[i] = 8'hff;
      end
   end
endmodule : jifp_flash_model
`default_nettype wire

// *** tb_top.sv ***
/* tb_top: self-checking bench for the indirect flash programmer.
   assumes: test port states driven here as levels, flash model on far side. */
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import jifp_pkg::*;
;
   localparam logic [15:0] LOCK_W = 16'hfbff;
   localparam logic [15:0] PORT   = JIFP_IR_BYTE_PORT;
   localparam logic [15:0] MODE   = JIFP_IR_MODE_CTRL;
   localparam logic [15:0] PTR    = JIFP_IR_TARGET;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        tck_pin = 1'b0;
   logic        tdi_pin = 1'b0;
   logic [15:0] ir_code = JIFP_IR_IDENT;
   logic        capture_dr = 1'b0;
   logic        shift_dr = 1'b0;
   logic        update_dr = 1'b0;
   logic [15:0] flash_wait = 16'h0002;
   logic        tdo_out, flash_req, flash_scratch, flash_all_user, flash_done, flash_fail;
   logic [1:0]  flash_cmd;
   logic [15:0] flash_addr;
   logic [7:0]  flash_wdata, flash_rdata;
   logic [19:0] d;
   int          fails = 0;
   int          n_checks = 0;
   int          n_req = 0;
   int          base = 0;
   int          cyc = 0;
   wire logic [31:0] id_exp = {JIFP_ID_VERSION, JIFP_ID_PART, JIFP_ID_MAKER, 1'b1};
   always #50 core_clk = ~core_clk;
   jifp_flash_programmer #(.LOCK_WR_ADDR(LOCK_W)) i_jifp_flash_programmer (.core_clk,
      .rst_n, .tck_pin, .tdi_pin, .ir_code, .capture_dr, .shift_dr, .update_dr, .tdo_out,
      .flash_req, .flash_cmd, .flash_scratch, .flash_all_user, .flash_addr, .flash_wdata,
      .flash_done, .flash_fail, .flash_rdata);
   jifp_flash_model i_jifp_flash_model (.core_clk, .rst_n, .flash_req, .flash_cmd,
      .flash_scratch, .flash_all_user, .flash_addr, .flash_wdata, .wait_cycles(flash_wait),
      .flash_done, .flash_fail, .flash_rdata);
   // count flash requests and cut a hang short
   always @(posedge core_clk)
   begin
      n_req += (flash_req === 1'b1);
      if (++cyc == 40000)
      begin
         fails++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (fails == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test
   task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   function automatic logic [19:0] mm(input logic [15:0] a);
      return {12'h0, i_jifp_flash_model.main_mem[a]};
   endfunction : mm
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step
   // link clock at 800 ns, only inside a scan
   task automatic tck_cycle();
      tck_pin = 1'b1;
      step(4);
      tck_pin = 1'b0;
      step(4);
   endtask : tck_cycle
   // capture, shift nb bits lsb first (left aligned), optional update
   task automatic scan(input logic [15:0] ir, input int nb, input logic [19:0] din,
                       input logic upd, output logic [19:0] dout);
      dout = 20'h0;
      ir_code = ir;
      capture_dr = 1'b1;
      tck_cycle();
      capture_dr = 1'b0;
      shift_dr = 1'b1;
      step(4);
      for (int i = 0; i < nb; i++)
      begin
         dout[i] = tdo_out;
         tdi_pin = din[20-nb+i];
         tck_cycle();
      end
      shift_dr = 1'b0;
      update_dr = upd;
      step(4);
      update_dr = 1'b0;
      step(4);
   endtask : scan
   // bounded poll; the capture that sees busy low also launches a held command
   task automatic wait_idle(input logic [15:0] ir, input int nb, output logic [19:0] v);
      v = 20'h1;
      for (int k = 0; k < 40 && v[0] !== 1'b0; k++)
         scan(ir, nb, 20'h0, 1'b0, v);
      chk("busy_low", 20'h0, {19'h0, v[0]});
   endtask : wait_idle
   task automatic rd_reg(input logic [15:0] ir, input int w, output logic [19:0] v);
      scan(ir, 2, 20'h80000, 1'b1, v);
      wait_idle(ir, w + 1, v);
      v = (v >> 1) & ((20'h1 << w) - 20'h1);
   endtask : rd_reg
   task automatic wr_reg(input logic [15:0] ir, input int w, input logic [17:0] val);
      logic [19:0] v;
      scan(ir, w + 2, {2'b11, val << (18 - w)}, 1'b1, v);
      wait_idle(ir, 1, v);
   endtask : wr_reg
   initial
   begin
      step(8);
      rst_n = 1'b1;
      step(4);
      rd_reg(MODE, 8, d);
      chk("mode_rst", {12'h0, JIFP_MODE_RST}, d);
      rd_reg(PORT, 10, d);
      chk("port_rst", {10'h0, JIFP_PORT_RST}, d);
      rd_reg(PTR, 16, d);
      chk("ptr_rst", {4'h0, JIFP_TGT_RST}, d);
      scan(JIFP_IR_IDENT, 20, 20'h0, 1'b0, d);
      chk("identity", id_exp[19:0], d);
      wr_reg(MODE, 8, 18'h10);
      wr_reg(PTR, 16, 18'h0123);
      wr_reg(PORT, 8, 18'h3c);
      chk("prog", 20'h3c, mm(16'h0123));
      rd_reg(PTR, 16, d);
      chk("ptr_prog", 20'h124, d);
      wr_reg(MODE, 8, 18'h00);
      base = n_req;
      wr_reg(PORT, 8, 18'h77);
      chk("store_req", 20'(base), 20'(n_req));
      rd_reg(PORT, 10, d);
      chk("hold", {10'h0, 8'h77, 2'b00}, d);
      wr_reg(MODE, 8, 18'h01);
      wr_reg(PTR, 16, 18'h0123);
      rd_reg(PORT, 10, d);
      chk("blk_first", {10'h0, 8'h77, 2'b00}, d);
      rd_reg(PORT, 10, d);
      chk("blk_data", {10'h0, 8'h3c, 2'b00}, d);
      rd_reg(PTR, 16, d);
      chk("ptr_reads", 20'h125, d);
      wr_reg(MODE, 8, 18'h20);
      wr_reg(PTR, 16, 18'h0123);
      base = n_req;
      wr_reg(PORT, 8, 18'h5a);
      chk("no_key", 20'(base), 20'(n_req));
      wr_reg(PORT, 8, 18'ha5);
      chk("erased", 20'hff, mm(16'h0123));
      rd_reg(PTR, 16, d);
      chk("ptr_erase", 20'h123, d);
      wr_reg(MODE, 8, 18'h90);
      wr_reg(PTR, 16, 18'h0005);
      wr_reg(PORT, 8, 18'h42);
      chk("scratch", 20'h42, {12'h0, i_jifp_flash_model.scr_mem[5]});
      chk("main_kept", 20'hff, mm(16'h0005));
      wr_reg(MODE, 8, 18'h10);
      wr_reg(PTR, 16, 18'h0400);
      wr_reg(PORT, 8, 18'h99);
      rd_reg(PORT, 10, d);
      chk("fail_flag", {10'h0, 8'h99, 2'b10}, d);
      wr_reg(PTR, 16, 18'h0300);
      flash_wait = 16'd300;
      base = n_req;
      scan(PORT, 10, {2'b11, 8'h11, 10'h0}, 1'b1, d);
      scan(PORT, 1, 20'h0, 1'b0, d);
      chk("busy_high", 20'h1, {19'h0, d[0]});
      scan(PORT, 10, {2'b11, 8'h22, 10'h0}, 1'b1, d);
      chk("held_off", 20'(base + 1), 20'(n_req));
      wait_idle(PORT, 1, d);
      wait_idle(PORT, 1, d);
      chk("first", 20'h11, mm(16'h0300));
      chk("replayed", 20'h22, mm(16'h0301));
      flash_wait = 16'h0002;
      wr_reg(MODE, 8, 18'h20);
      wr_reg(PTR, 16, {2'b00, LOCK_W});
      wr_reg(PORT, 8, 18'ha5);
      chk("whole", 20'hff, mm(16'h0301));
      // single-byte read mode: the second port read finds unconsumed data and starts nothing
      wr_reg(MODE, 8, 18'h02);
      base = n_req;
      rd_reg(PORT, 10, d);
      rd_reg(PORT, 10, d);
      chk("single_data", {10'h0, 8'hff, 2'b00}, d);
      chk("single_req", 20'(base + 1), 20'(n_req));
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
